/* File: pid_cfg.svh */
// pid_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name, APB byte addresses, 250 MHz clock
`ifndef PID_CFG_SVH
`define PID_CFG_SVH
`define PID_ADDR_W 8
`define PID_OFF_CTRL 8'h00
`define PID_OFF_EDGE_SEL 8'h04
`define PID_OFF_TMR_PERIOD 8'h08
`define PID_OFF_PORT1_END 8'h0c
`define PID_OFF_PORT2_END 8'h10
`define PID_OFF_PORT3_END 8'h14
`define PID_OFF_CAPTURE_A 8'h18
`define PID_OFF_CAPTURE_B 8'h1c
`define PID_OFF_IRQ_STATUS 8'h20
`define PID_OFF_IRQ_ENABLE 8'h24
`define PID_OFF_IRQ_CLEAR 8'h28
`define PID_OFF_SEQ_STATE 8'h2c
`define PID_OFF_PENDING 8'h30
`define PID_CTRL_TMR_EN 0
`define PID_CTRL_TMR_FINE 1
`define PID_CTRL_CAP_A_EN 2
`define PID_CTRL_CAP_B_EN 3
`define PID_CTRL_RST 4'h0
`define PID_EDGE_SEL_RST 8'hff
`define PID_TMR_PERIOD_RST 7'h0a
`define PID_END_CHAR_RST 16'h000d
`define PID_IRQ_W 6
`define PID_NSRC 28
`define PID_SRC_TMR 16
`define PID_SRC_CNT 17
`define PID_SRC_SER 25
`define PID_VEC_TIMER 10'h262
`define PID_VEC_SER_BASE 10'h08c
`define PID_CLK_MHZ 250
`define PID_TICK_COARSE_US 1000
`define PID_TICK_FINE_US 100
`define PID_TICK_COARSE_CYC (`PID_TICK_COARSE_US * `PID_CLK_MHZ)
`define PID_TICK_FINE_CYC (`PID_TICK_FINE_US * `PID_CLK_MHZ)
`endif

/* File: pid_dispatch.sv */
// pid_dispatch.sv: interrupt dispatch for the instruction sequencer, with APB registers
// assumes: sequencer strobes on mclk_in; input lines are asynchronous pins
//
// Contract
// - any of eight lines' edge raises interrupt
// - rising edge takes vector ending 01
// - four categories: edge, timer, counter, serial
// - dispatch only between enable and disable; code still dispatches at the disable instruction's own boundary
// - test pending after every executed instruction; code tests only in the main program, and not at a return instruction
// - pending request starts handler at next boundary
// - return instruction resumes at saved address
// - periodic timer, 2-99ms or 0.2-9.9ms period
// - counter compare match, eight counter vectors
// - received byte matches end-character low byte
// - lines one/four capture counter A value
// - lines three/five capture counter B value
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "pid_cfg.svh"
module pid_dispatch #(
  parameter int PC_W = 16,
  parameter int TICK_COARSE_CYC = `PID_TICK_COARSE_CYC,
  parameter int TICK_FINE_CYC = `PID_TICK_FINE_CYC
) (
  // clock, reset, enable
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`PID_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // sequencer
  input wire logic instr_done_in,
  input wire logic irq_enable_instruction_in,
  input wire logic irq_disable_instruction_in,
  input wire logic irq_return_instruction_in,
  input wire logic [PC_W-1:0] next_pc_in,
  output logic redirect_out,
  output pid_pkg::pid_vector_type vector_out,
  output logic resume_out,
  output logic [PC_W-1:0] resume_addr_out,
  // sources
  input wire logic [7:0] ext_line_in,
  input wire logic [7:0] cmp_match_in,
  input wire logic [31:0] counter_in0_in,
  input wire logic [31:0] counter_in2_in,
  input wire logic [2:0] rx_valid_in,
  input wire logic [23:0] rx_data_in,
  // interrupt
  output logic irq_out
);
  import pid_pkg::*;

  logic [3:0] ctrl_reg;
  logic [7:0] edge_sel_reg;
  logic [6:0] tmr_period_reg;
  logic [15:0] port1_end_character_reg;
  logic [15:0] port2_end_character_reg;
  logic [15:0] port3_end_character_reg;
  logic [31:0] capture_pair_a_reg;
  logic [31:0] capture_pair_b_reg;
  logic [`PID_IRQ_W-1:0] irq_status_reg;
  logic [`PID_IRQ_W-1:0] irq_enable_reg;
  logic [`PID_NSRC-1:0] pending_reg;
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] line_prev_reg;
  logic [17:0] prescale_reg;
  logic [6:0] tick_cnt_reg;
  logic irq_en_reg;
  pid_seq_state_type state_reg;
  logic [PC_W-1:0] saved_pc_reg;

  logic wr_acc;
  logic wr_clear;
  logic [`PID_IRQ_W-1:0] clear_bits;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] ext_fire;
  logic tmr_fire;
  logic [2:0] ser_fire;
  logic [`PID_NSRC-1:0] src_set;
  logic [`PID_NSRC-1:0] take_mask;
  logic [`PID_IRQ_W-1:0] irq_set;
  logic cap_a_hit;
  logic cap_b_hit;
  logic do_dispatch;
  logic do_return;
  logic [4:0] sel_idx;
  logic sel_any;
  logic [17:0] tick_len;

  // apb handshake
  assign wr_acc = psel_in & penable_in & pready_out & pwrite_in;
  assign wr_clear = wr_acc && (paddr_in == `PID_OFF_IRQ_CLEAR);
  assign clear_bits = wr_clear ? pwdata_in[`PID_IRQ_W-1:0] : '0;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else if (ce_in) begin
      pready_out <= psel_in & ~penable_in;
      pslverr_out <= 1'b0;
      if (psel_in & ~penable_in) begin
        prdata_out <= 32'h0000_0000;
        if (paddr_in == `PID_OFF_CTRL) begin
          prdata_out <= {28'h0, ctrl_reg};
        end else if (paddr_in == `PID_OFF_EDGE_SEL) begin
          prdata_out <= {24'h0, edge_sel_reg};
        end else if (paddr_in == `PID_OFF_TMR_PERIOD) begin
          prdata_out <= {25'h0, tmr_period_reg};
        end else if (paddr_in == `PID_OFF_PORT1_END) begin
          prdata_out <= {16'h0, port1_end_character_reg};
        end else if (paddr_in == `PID_OFF_PORT2_END) begin
          prdata_out <= {16'h0, port2_end_character_reg};
        end else if (paddr_in == `PID_OFF_PORT3_END) begin
          prdata_out <= {16'h0, port3_end_character_reg};
        end else if (paddr_in == `PID_OFF_CAPTURE_A) begin
          prdata_out <= capture_pair_a_reg;
        end else if (paddr_in == `PID_OFF_CAPTURE_B) begin
          prdata_out <= capture_pair_b_reg;
        end else if (paddr_in == `PID_OFF_IRQ_STATUS) begin
          prdata_out <= {26'h0, irq_status_reg};
        end else if (paddr_in == `PID_OFF_IRQ_ENABLE) begin
          prdata_out <= {26'h0, irq_enable_reg};
        end else if (paddr_in == `PID_OFF_IRQ_CLEAR) begin
          prdata_out <= 32'h0000_0000;
        end else if (paddr_in == `PID_OFF_SEQ_STATE) begin
          prdata_out <= {14'h0, saved_pc_reg, state_reg, irq_en_reg};
        end else if (paddr_in == `PID_OFF_PENDING) begin
          prdata_out <= {4'h0, pending_reg};
        end else begin
          pslverr_out <= 1'b1;
        end
      end
    end
  end

  // software registers
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_reg <= `PID_CTRL_RST;
      edge_sel_reg <= `PID_EDGE_SEL_RST;
      tmr_period_reg <= `PID_TMR_PERIOD_RST;
      port1_end_character_reg <= `PID_END_CHAR_RST;
      port2_end_character_reg <= `PID_END_CHAR_RST;
      port3_end_character_reg <= `PID_END_CHAR_RST;
      irq_enable_reg <= '0;
    end else if (ce_in && wr_acc) begin
      if (paddr_in == `PID_OFF_CTRL) begin
        ctrl_reg <= pwdata_in[3:0];
      end else if (paddr_in == `PID_OFF_EDGE_SEL) begin
        edge_sel_reg <= pwdata_in[7:0];
      end else if (paddr_in == `PID_OFF_TMR_PERIOD) begin
        tmr_period_reg <= pwdata_in[6:0];
      end else if (paddr_in == `PID_OFF_PORT1_END) begin
        port1_end_character_reg <= pwdata_in[15:0];
      end else if (paddr_in == `PID_OFF_PORT2_END) begin
        port2_end_character_reg <= pwdata_in[15:0];
      end else if (paddr_in == `PID_OFF_PORT3_END) begin
        port3_end_character_reg <= pwdata_in[15:0];
      end else if (paddr_in == `PID_OFF_IRQ_ENABLE) begin
        irq_enable_reg <= pwdata_in[`PID_IRQ_W-1:0];
      end
    end
  end

  // input line synchroniser and edge detect
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      line_prev_reg <= 8'h00;
    end else if (ce_in) begin
      sync1_reg <= ext_line_in;
      sync2_reg <= sync1_reg;
      line_prev_reg <= sync2_reg;
    end
  end
  assign rise = sync2_reg & ~line_prev_reg;
  assign fall = ~sync2_reg & line_prev_reg;
  assign ext_fire = (edge_sel_reg & rise) | (~edge_sel_reg & fall);

  // periodic timer
  assign tick_len = ctrl_reg[`PID_CTRL_TMR_FINE] ? 18'(TICK_FINE_CYC) : 18'(TICK_COARSE_CYC);
  assign tmr_fire = ctrl_reg[`PID_CTRL_TMR_EN] && (prescale_reg >= tick_len - 18'h1)
    && (tick_cnt_reg + 7'h1 >= tmr_period_reg);
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prescale_reg <= 18'h0;
      tick_cnt_reg <= 7'h0;
    end else if (ce_in) begin
      if (!ctrl_reg[`PID_CTRL_TMR_EN]) begin
        prescale_reg <= 18'h0;
        tick_cnt_reg <= 7'h0;
      end else if (prescale_reg >= tick_len - 18'h1) begin
        prescale_reg <= 18'h0;
        tick_cnt_reg <= tmr_fire ? 7'h0 : tick_cnt_reg + 7'h1;
      end else begin
        prescale_reg <= prescale_reg + 18'h1;
      end
    end
  end

  // serial end-character match
  assign ser_fire[0] = rx_valid_in[0] && (rx_data_in[7:0] == port1_end_character_reg[7:0]);
  assign ser_fire[1] = rx_valid_in[1] && (rx_data_in[15:8] == port2_end_character_reg[7:0]);
  assign ser_fire[2] = rx_valid_in[2] && (rx_data_in[23:16] == port3_end_character_reg[7:0]);

  // request set vector, two slots per line
  always_comb begin
    src_set = '0;
    for (int i = 0; i < 8; i++) begin
      src_set[2*i] = edge_sel_reg[i] & rise[i];
      src_set[2*i+1] = ~edge_sel_reg[i] & fall[i];
    end
    src_set[`PID_SRC_TMR] = tmr_fire;
    src_set[`PID_SRC_CNT +: 8] = cmp_match_in;
    src_set[`PID_SRC_SER +: 3] = ser_fire;
  end

  // fixed priority select, lowest index first
  always_comb begin
    sel_idx = 5'h0;
    sel_any = 1'b0;
    for (int i = `PID_NSRC - 1; i >= 0; i--) begin
      if (pending_reg[i]) begin
        sel_idx = 5'(i);
        sel_any = 1'b1;
      end
    end
  end

  function automatic pid_vector_type vec_of(input logic [4:0] idx);
    pid_vector_type v;
    v = 10'h000;
    if (idx < 5'd16) begin
      v = 10'(idx[4:1]) * 10'd100 + {9'h0, ~idx[0]};
    end else if (idx == 5'd16) begin
      v = `PID_VEC_TIMER;
    end else if (idx < 5'd25) begin
      v = 10'(idx - 5'd16) * 10'd10;
    end else begin
      v = `PID_VEC_SER_BASE + 10'(idx - 5'd25) * 10'd10;
    end
    return v;
  endfunction : vec_of

  assign do_return = instr_done_in && irq_return_instruction_in && state_reg == PID_RUN_HANDLER;
  assign do_dispatch = instr_done_in && !irq_return_instruction_in && irq_en_reg
    && state_reg == PID_RUN_MAIN && sel_any;
  assign take_mask = do_dispatch ? (`PID_NSRC'(1) << sel_idx) : '0;

  // pending requests, new request wins over its own take
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pending_reg <= '0;
    end else if (ce_in) begin
      pending_reg <= (pending_reg & ~take_mask) | src_set;
    end
  end

  // sequencer control
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_en_reg <= 1'b0;
      state_reg <= PID_RUN_MAIN;
      saved_pc_reg <= '0;
      redirect_out <= 1'b0;
      vector_out <= 10'h000;
      resume_out <= 1'b0;
      resume_addr_out <= '0;
    end else if (ce_in) begin
      redirect_out <= 1'b0;
      resume_out <= 1'b0;
      if (instr_done_in && irq_enable_instruction_in) begin
        irq_en_reg <= 1'b1;
      end else if (instr_done_in && irq_disable_instruction_in) begin
        irq_en_reg <= 1'b0;
      end
      case (state_reg)
        PID_RUN_MAIN: begin
          if (do_dispatch) begin
            saved_pc_reg <= next_pc_in;
            redirect_out <= 1'b1;
            vector_out <= vec_of(sel_idx);
            state_reg <= PID_RUN_HANDLER;
          end
        end
        PID_RUN_HANDLER: begin
          if (do_return) begin
            resume_out <= 1'b1;
            resume_addr_out <= saved_pc_reg;
            state_reg <= PID_RUN_MAIN;
          end
        end
        default: state_reg <= PID_RUN_MAIN;
      endcase
    end
  end

  // counter capture on selected lines
  assign cap_a_hit = ctrl_reg[`PID_CTRL_CAP_A_EN] && (ext_fire[1] || ext_fire[4]);
  assign cap_b_hit = ctrl_reg[`PID_CTRL_CAP_B_EN] && (ext_fire[3] || ext_fire[5]);
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      capture_pair_a_reg <= 32'h0000_0000;
      capture_pair_b_reg <= 32'h0000_0000;
    end else if (ce_in) begin
      if (cap_a_hit) begin
        capture_pair_a_reg <= counter_in0_in;
      end
      if (cap_b_hit) begin
        capture_pair_b_reg <= counter_in2_in;
      end
    end
  end

  // sticky status, set wins over clear
  assign irq_set = {cap_b_hit, cap_a_hit, |ser_fire, |cmp_match_in, tmr_fire, |ext_fire};
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_status_reg <= '0;
      irq_out <= 1'b0;
    end else if (ce_in) begin
      irq_status_reg <= (irq_status_reg & ~clear_bits) | irq_set;
      irq_out <= |(((irq_status_reg & ~clear_bits) | irq_set) & irq_enable_reg);
    end
  end

endmodule : pid_dispatch

/* File: pid_dispatch_props.sv */
// checker: concurrent properties on the dispatch block ports
// assumes: bound onto pid_dispatch by the testbench top
`timescale 1ns/1ps
module pid_dispatch_props #(
  parameter int PC_W = 16
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // sequencer
  input wire logic instr_done_in,
  input wire logic irq_enable_instruction_in,
  input wire logic irq_disable_instruction_in,
  input wire logic irq_return_instruction_in,
  input wire logic [PC_W-1:0] next_pc_in,
  input wire logic redirect_out,
  input wire pid_pkg::pid_vector_type vector_out,
  input wire logic resume_out,
  input wire logic [PC_W-1:0] resume_addr_out
);
  import pid_pkg::*;
  logic en_q;
  logic hnd_q;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] sv_q;
  function automatic logic ok_vec(input pid_vector_type v);
    return v == 10'h262 || v == 10'h08c || v == 10'h096 || v == 10'h0a0 ||
      (v % 10'h00a == 10'h000 && v >= 10'h00a && v <= 10'h050) ||
      (v % 10'h064 <= 10'h001 && v < 10'h320);
  endfunction : ok_vec
  // enable state, handler state and saved address seen from the ports
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_q <= 1'b0;
      hnd_q <= 1'b0;
      pc_q <= '0;
      sv_q <= '0;
    end else begin
      if (instr_done_in && irq_enable_instruction_in) en_q <= 1'b1;
      else if (instr_done_in && irq_disable_instruction_in) en_q <= 1'b0;
      if (instr_done_in) pc_q <= next_pc_in;
      if (redirect_out) sv_q <= pc_q;
      if (redirect_out) hnd_q <= 1'b1;
      else if (resume_out) hnd_q <= 1'b0;
    end
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);
  AST_DISPATCH_EN: assert property (redirect_out |-> $past(en_q))
    else $error("dispatch while disabled");
  AST_BOUNDARY: assert property (redirect_out |->
    $past(instr_done_in && !irq_return_instruction_in)) else $error("dispatch off boundary");
  AST_NO_NEST: assert property (redirect_out |-> !hnd_q)
    else $error("dispatch inside handler");
  AST_ONE_SHOT: assert property (redirect_out |=> !redirect_out)
    else $error("redirect longer than one cycle");
  AST_RESUME_SRC: assert property (resume_out |->
    hnd_q && $past(instr_done_in && irq_return_instruction_in)) else $error("stray resume");
  AST_RESUME_ADDR: assert property (resume_out |-> resume_addr_out == sv_q)
    else $error("resume address wrong");
  AST_VEC_LEGAL: assert property (redirect_out |-> ok_vec(vector_out))
    else $error("illegal handler code");
  AST_VEC_HOLD: assert property (!redirect_out |-> $stable(vector_out))
    else $error("handler code moved");
  cover property (redirect_out);
  cover property (resume_out);
  cover property (redirect_out && vector_out == 10'h262);
endmodule : pid_dispatch_props

/* File: pid_pkg.sv */
// pid_pkg.sv: types of the interrupt dispatch block
// assumes: pid_cfg.svh holds the register offsets, reset values, source indices and timing counts
package pid_pkg;
  typedef enum logic [0:0] {
    PID_RUN_MAIN = 1'b0,
    PID_RUN_HANDLER = 1'b1
  } pid_seq_state_type;
  typedef logic [9:0] pid_vector_type;
endpackage : pid_pkg

/* File: pid_src_model.sv */
// model: input lines, counters and serial receivers
// assumes: tasks called from the testbench, one at a time
`timescale 1ns/1ps
module pid_src_model (
  // clock
  input wire logic mclk_in,
  // sources
  output logic [7:0] ext_line_out,
  output logic [7:0] cmp_match_out,
  output logic [31:0] cnt_a_out,
  output logic [31:0] cnt_b_out,
  output logic [2:0] rx_valid_out,
  output logic [23:0] rx_data_out
);
  initial begin
    ext_line_out = 8'h00;
    cmp_match_out = 8'h00;
    cnt_a_out = 32'h0;
    cnt_b_out = 32'h0;
    rx_valid_out = 3'h0;
    rx_data_out = 24'h0;
  end
  task line(input int k, input logic v);
    @(posedge mclk_in) ext_line_out[k] <= v;
  endtask : line
  task cmp(input int k);
    @(posedge mclk_in) cmp_match_out[k] <= 1'b1;
    @(posedge mclk_in) cmp_match_out[k] <= 1'b0;
  endtask : cmp
  task rx(input int p, input logic [7:0] b);
    @(posedge mclk_in) rx_valid_out[p] <= 1'b1;
    rx_data_out[8*p+:8] <= b;
    @(posedge mclk_in) rx_valid_out[p] <= 1'b0;
    rx_data_out <= ~rx_data_out;
  endtask : rx
  task counts(input logic [31:0] a, b);
    @(posedge mclk_in) cnt_a_out <= a;
    cnt_b_out <= b;
  endtask : counts
endmodule : pid_src_model

/* File: tb_top.sv */
// testbench: random and corner scenarios for the dispatch block
// assumes: pid_src_model drives the sources, checker bound below
`timescale 1ns/1ps
`include "pid_cfg.svh"
module tb_top;
  import pid_pkg::*;
  logic mclk_in = 1'b0, arst_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
  logic pwrite_in = 1'b0, instr_done_in = 1'b0, irq_enable_instruction_in = 1'b0;
  logic irq_disable_instruction_in = 1'b0, irq_return_instruction_in = 1'b0;
  logic [7:0] paddr_in = 8'h00, ext_line_in, cmp_match_in;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd, va, vb, counter_in0_in, counter_in2_in;
  logic [15:0] next_pc_in = 16'h0, resume_addr_out;
  logic pready_out, pslverr_out, redirect_out, resume_out, irq_out, err, got;
  logic [2:0] rx_valid_in;
  logic [23:0] rx_data_in;
  pid_vector_type vector_out, gv;
  int bad_count = 0, num_checks = 0, k, p;
  initial forever #2 mclk_in = ~mclk_in;
  pid_dispatch #(.TICK_COARSE_CYC(20), .TICK_FINE_CYC(4)) pid_dispatch_i (.mclk_in, .arst_n_in,
    .ce_in(1'b1), .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
    .pready_out, .pslverr_out, .instr_done_in, .irq_enable_instruction_in,
    .irq_disable_instruction_in, .irq_return_instruction_in, .next_pc_in, .redirect_out,
    .vector_out, .resume_out, .resume_addr_out, .ext_line_in, .cmp_match_in, .counter_in0_in,
    .counter_in2_in, .rx_valid_in, .rx_data_in, .irq_out);
  pid_src_model pid_src_model_i (.mclk_in, .ext_line_out(ext_line_in),
    .cmp_match_out(cmp_match_in), .cnt_a_out(counter_in0_in), .cnt_b_out(counter_in2_in),
    .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in));
  // kind 0 falling line, 1 rising line, 2 counter, 3 serial port
  function automatic pid_vector_type exp_vec(input int c, n);
    return c < 2 ? 10'(n * 'h64 + c) : c == 2 ? 10'((n + 1) * 'ha) : 10'('h8c + 'ha * n);
  endfunction : exp_vec
  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do @(posedge mclk_in); while (pready_out !== 1'b1 && ++n < 16);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (pready_out !== 1'b1) begin
      chk("pready", 1'b0, 1'b1);
      report_and_stop();
    end
  endtask : apb
  // f bits: return, disable, enable
  task automatic instr(input logic [2:0] f, input logic [15:0] pc);
    @(posedge mclk_in);
    instr_done_in <= 1'b1;
    {irq_return_instruction_in, irq_disable_instruction_in, irq_enable_instruction_in} <= f;
    next_pc_in <= pc;
    @(posedge mclk_in);
    instr_done_in <= 1'b0;
    @(negedge mclk_in);
    got = redirect_out;
    gv = vector_out;
  endtask : instr
  task automatic take(input int c, n, input logic [15:0] pc);
    instr(3'h0, pc);
    chk("redirect", got, 1'b1);
    chk("vector", gv, exp_vec(c, n));
    instr(3'h4, 16'h0);
    chk("resume", resume_out, 1'b1);
    chk("resume_addr", resume_addr_out, pc);
  endtask : take
  initial begin
    void'($urandom(32'h9649bc0e));
    repeat (8) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    apb(1'b0, `PID_OFF_EDGE_SEL, 32'h0);
    chk("edge_sel", rd, 32'hff);
    apb(1'b0, `PID_OFF_TMR_PERIOD, 32'h0);
    chk("period", rd, 32'h0a);
    for (p = 0; p < 3; p++) begin
      apb(1'b0, 8'(`PID_OFF_PORT1_END + 4 * p), 32'h0);
      chk("end_char", rd, 32'h0d);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", err, 1'b1);
    $display("test reset done");
    k = $urandom_range(7);
    instr(3'h1, 16'h0);
    instr(3'h0, 16'h0);
    chk("idle", got, 1'b0);
    apb(1'b1, `PID_OFF_IRQ_ENABLE, 32'h1);
    pid_src_model_i.line(k, 1'b1);
    repeat (8) @(negedge mclk_in);
    chk("irq", irq_out, 1'b1);
    va = $urandom;
    take(1, k, va[15:0]);
    apb(1'b0, `PID_OFF_IRQ_STATUS, 32'h0);
    chk("status", rd, 32'h1);
    apb(1'b1, `PID_OFF_IRQ_ENABLE, 32'h0);
    repeat (2) @(negedge mclk_in);
    chk("masked", irq_out, 1'b0);
    apb(1'b1, `PID_OFF_IRQ_CLEAR, 32'h3f);
    apb(1'b0, `PID_OFF_IRQ_STATUS, 32'h0);
    chk("cleared", rd, 32'h0);
    apb(1'b1, `PID_OFF_EDGE_SEL, ~(32'h1 << k) & 32'hff);
    pid_src_model_i.line(k, 1'b0);
    repeat (8) @(posedge mclk_in);
    take(0, k, va[31:16]);
    apb(1'b1, `PID_OFF_EDGE_SEL, 32'hff);
    $display("test ext done");
    va = $urandom;
    vb = $urandom;
    pid_src_model_i.counts(va, vb);
    apb(1'b1, `PID_OFF_CTRL, 32'hc);
    pid_src_model_i.line(1, 1'b1);
    pid_src_model_i.line(3, 1'b1);
    repeat (8) @(posedge mclk_in);
    apb(1'b0, `PID_OFF_CAPTURE_A, 32'h0);
    chk("cap_a", rd, va);
    apb(1'b0, `PID_OFF_CAPTURE_B, 32'h0);
    chk("cap_b", rd, vb);
    take(1, 1, va[15:0]);
    take(1, 3, vb[15:0]);
    $display("test capture done");
    k = $urandom_range(7);
    instr(3'h2, 16'h0);
    pid_src_model_i.cmp(k);
    repeat (3) @(posedge mclk_in);
    instr(3'h0, 16'h0);
    chk("disabled", got, 1'b0);
    instr(3'h1, 16'h0);
    take(2, k, va[31:16]);
    $display("test counter done");
    p = $urandom_range(2);
    va = $urandom;
    apb(1'b1, 8'(`PID_OFF_PORT1_END + 4 * p), {16'h0, va[15:0]});
    apb(1'b0, 8'(`PID_OFF_PORT1_END + 4 * p), 32'h0);
    chk("end_rw", rd, {16'h0, va[15:0]});
    pid_src_model_i.rx(p, va[7:0] ^ 8'h01);
    repeat (3) @(posedge mclk_in);
    instr(3'h0, 16'h0);
    chk("no_match", got, 1'b0);
    pid_src_model_i.rx(p, va[7:0]);
    repeat (3) @(posedge mclk_in);
    take(3, p, va[31:16]);
    $display("test serial done");
    apb(1'b1, `PID_OFF_TMR_PERIOD, 32'h2);
    apb(1'b1, `PID_OFF_CTRL, 32'h1);
    got = 1'b0;
    for (k = 0; k < 100 && got !== 1'b1; k++) instr(3'h0, 16'h0);
    chk("timer", gv, `PID_VEC_TIMER);
    instr(3'h4, 16'h0);
    apb(1'b1, `PID_OFF_CTRL, 32'h3);
    for (p = 0; p < 2; p++) begin
      got = 1'b0;
      for (k = 0; k < 100 && got !== 1'b1; k++) instr(3'h0, 16'h0);
      chk("timer_fine", gv, `PID_VEC_TIMER);
      instr(3'h4, 16'h0);
    end
    chk("fine_period", k <= 6, 1'b1);
    $display("test timer done");
    report_and_stop();
  end
endmodule : tb_top
bind pid_dispatch pid_dispatch_props #(.PC_W(PC_W)) pid_dispatch_props_i (.mclk_in,
  .arst_n_in, .instr_done_in, .irq_enable_instruction_in, .irq_disable_instruction_in,
  .irq_return_instruction_in, .next_pc_in, .redirect_out, .vector_out, .resume_out,
  .resume_addr_out);
